// ---- cmac_top.sv ----
/*
  Address selection, mux parking, sampling delay, conversion correction,
  save request and fault write-blocking of a stackable cell monitor.
  Assumes synchronous inputs, one-cycle strobes from the link and front end,
  and a register master that never issues read and write together.
*/
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cmac_params.svh"

module cmac_top
  import cmac_pkg::*;
#(
  parameter int unsigned P_PARK_DELAY_CYC = `CMAC_PARK_DELAY_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output var  logic [15:0] o_rdata,
  input  wire logic [4:0]  i_gpio_addr,
  input  wire logic [4:0]  i_nvm_addr,
  input  wire logic        i_nvm_addr_sel,
  output var  logic [4:0]  o_address_field,
  output var  logic        o_nvm_save,
  input  wire logic        i_frame_done,
  output var  logic        o_hs_tx_en,
  input  wire logic        i_acq_active,
  input  wire logic [3:0]  i_conv_chan,
  output var  logic [3:0]  o_mux_sel,
  input  wire logic        i_sample_req,
  input  wire logic        i_sample_done,
  output var  logic        o_sample_go,
  input  wire logic        i_raw_valid,
  input  wire logic [4:0]  i_raw_chan,
  input  wire logic [15:0] i_raw_data,
  input  wire logic [15:0] i_fact_gain,
  input  wire logic [15:0] i_fact_offs,
  output var  logic        o_corr_valid,
  output var  logic [4:0]  o_corr_chan,
  output var  logic [15:0] o_corr_data,
  input  wire logic        i_fault,
  output var  logic        o_wr_blocked
);

  localparam int unsigned BLOCK_CYC = `CMAC_BLOCK_CYC;

  // gain is scaled by the input: x * g / 2^16, then offset added, clamped
  function automatic logic [15:0] cmac_corr(input logic [15:0] x,
                                            input logic signed [15:0] g,
                                            input logic signed [15:0] o);
    logic signed [33:0] xs;
    logic signed [33:0] p;
    logic signed [33:0] s;
    xs = $signed({18'h0, x});
    p  = xs * 34'(g);
    s  = xs + (p >>> 16) + 34'(o);
    if (s < 0) begin
      cmac_corr = 16'h0000;
    end else if (s > 34'sh0FFFF) begin
      cmac_corr = 16'hFFFF;
    end else begin
      cmac_corr = s[15:0];
    end
  endfunction

  function automatic logic [3:0] cmac_top_chan(input logic [15:0] m);
    cmac_top_chan = 4'hF;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        cmac_top_chan = 4'(i);
      end
    end
  endfunction

  logic [15:0] chsel_r;
  logic [7:0]  cgain_r;
  logic [7:0]  coffs_r;
  logic [15:0] aux_offs_r [8];
  logic [15:0] key1_r;
  logic [15:0] key2_r;
  logic [4:0]  addr_r;
  logic        addr_sel_r;
  logic        bal_stop_r;
  logic [15:0] bal_en_r;
  logic        park_req_r;
  logic        park_act_r;
  logic        init_done_r;
  logic [15:0] rdata_nxt;
  logic [15:0] park_cnt_r;
  logic [7:0]  blk_cnt_r;
  logic        blocked;
  logic        wr_ok;
  logic        ctl_wr;
  logic        key_ok;
  cmac_smp_t   smp_r;
  cmac_adr_t   adr_r;
  logic        s1_valid_r;
  logic [4:0]  s1_chan_r;
  logic [15:0] s1_data_r;

  assign blocked = (blk_cnt_r != 8'h00);
  assign wr_ok   = i_wr & ~blocked;  // [RL22]
  assign ctl_wr  = wr_ok & (i_addr == `CMAC_OFS_DEVCTL);
  assign key_ok  = (key1_r == `CMAC_KEY1_VAL) && (key2_r == `CMAC_KEY2_VAL);

  // plain configuration registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chsel_r    <= `CMAC_CHSEL_RST;
      cgain_r    <= 8'h00;
      coffs_r    <= 8'h00;
      bal_stop_r <= 1'b0;
      bal_en_r   <= 16'h0000;
      park_req_r <= 1'b0;
    end else if (wr_ok) begin
      case (i_addr)
        `CMAC_OFS_CHSEL:  chsel_r    <= i_wdata;
        `CMAC_OFS_CGAIN:  cgain_r    <= i_wdata[7:0];  // [RL7]
        `CMAC_OFS_COFFS:  coffs_r    <= i_wdata[7:0];  // [RL9]
        `CMAC_OFS_BALCFG: bal_stop_r <= i_wdata[`CMAC_BAL_STOP_BIT];
        `CMAC_OFS_BALEN:  bal_en_r   <= i_wdata;
        `CMAC_OFS_PARK:   park_req_r <= i_wdata[`CMAC_PARK_BIT];
        default: ;
      endcase
    end
  end

  // per-channel aux offsets, held at full 16-bit width
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < 8; i++) begin
        aux_offs_r[i] <= 16'h0000;
      end
    end else if (wr_ok && i_addr >= `CMAC_OFS_AUX0 && i_addr <= `CMAC_OFS_AUX7) begin
      aux_offs_r[3'(i_addr - `CMAC_OFS_AUX0)] <= i_wdata;  // [RL10]
    end
  end

  // unlock keys and save request; keys are consumed by a save
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      key1_r     <= 16'h0000;
      key2_r     <= 16'h0000;
      o_nvm_save <= 1'b0;
    end else begin
      o_nvm_save <= ctl_wr & i_wdata[`CMAC_CTL_SAVE_BIT] & key_ok;  // [RL13]
      if (ctl_wr && i_wdata[`CMAC_CTL_SAVE_BIT]) begin
        key1_r <= 16'h0000;
        key2_r <= 16'h0000;
      end else begin
        if (wr_ok && i_addr == `CMAC_OFS_KEY1) begin
          key1_r <= i_wdata;
        end
        if (wr_ok && i_addr == `CMAC_OFS_KEY2) begin
          key2_r <= i_wdata;
        end
      end
    end
  end

  // address source select, reloaded from storage after reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_sel_r  <= 1'b0;
      init_done_r <= 1'b0;
    end else begin
      init_done_r <= 1'b1;
      if (!init_done_r) begin
        addr_sel_r <= i_nvm_addr_sel;
      end else if (wr_ok && i_addr == `CMAC_OFS_DEVCFG) begin
        addr_sel_r <= i_wdata[`CMAC_CFG_SEL_BIT];
      end
    end
  end

  // address field
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_r <= 5'h00;
    end else if (!init_done_r) begin
      addr_r <= i_nvm_addr_sel ? i_nvm_addr : i_gpio_addr;  // [RL14] [RL15]
    end else if (ctl_wr && i_wdata[`CMAC_CTL_AUTO_BIT] && !addr_sel_r) begin
      addr_r <= i_gpio_addr;  // [RL15]
    end else if (wr_ok && i_addr == `CMAC_OFS_ADDR && adr_r == CMAC_ADR_AUTO) begin
      addr_r <= i_wdata[4:0];  // [RL17] [RL19]
    end
  end

  // auto addressing: high-side transmit held off for one received frame
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      adr_r      <= CMAC_ADR_NORM;
      o_hs_tx_en <= 1'b1;
    end else begin
      case (adr_r)
        CMAC_ADR_NORM: begin
          if (ctl_wr && i_wdata[`CMAC_CTL_AUTO_BIT] && addr_sel_r) begin
            adr_r      <= CMAC_ADR_AUTO;  // [RL16]
            o_hs_tx_en <= 1'b0;  // [RL17]
          end
        end
        CMAC_ADR_AUTO: begin
          if (i_frame_done) begin
            adr_r      <= CMAC_ADR_NORM;  // [RL18]
            o_hs_tx_en <= 1'b1;  // [RL18]
          end
        end
        default: begin
          adr_r      <= CMAC_ADR_NORM;
          o_hs_tx_en <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_address_field <= 5'h00;
    end else begin
      o_address_field <= addr_r;
    end
  end

  // write-blocking window after a fault while balancing
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      blk_cnt_r    <= 8'h00;
      o_wr_blocked <= 1'b0;
    end else begin
      if (i_fault && bal_stop_r && bal_en_r != 16'h0000) begin
        blk_cnt_r    <= 8'(BLOCK_CYC);  // [RL22]
        o_wr_blocked <= 1'b1;
      end else if (blocked) begin
        blk_cnt_r    <= blk_cnt_r - 8'h01;
        o_wr_blocked <= (blk_cnt_r != 8'h01);
      end
    end
  end

  // park bit becomes active only once the next front-end sample completes
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      park_act_r <= 1'b0;
    end else if (i_sample_done) begin
      park_act_r <= park_req_r;  // [RL3]
    end
  end

  // sampling request delay
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      smp_r       <= CMAC_SMP_IDLE;
      park_cnt_r  <= 16'h0000;
      o_sample_go <= 1'b0;
    end else begin
      o_sample_go <= 1'b0;
      case (smp_r)
        CMAC_SMP_IDLE: begin
          if (i_sample_req) begin
            if (park_act_r) begin
              smp_r      <= CMAC_SMP_WAIT;  // [RL2]
              park_cnt_r <= 16'h0000;
            end else begin
              o_sample_go <= 1'b1;
            end
          end
        end
        CMAC_SMP_WAIT: begin
          if (park_cnt_r == 16'(P_PARK_DELAY_CYC - 1)) begin
            smp_r       <= CMAC_SMP_IDLE;
            o_sample_go <= 1'b1;  // [RL2]
          end else begin
            park_cnt_r <= park_cnt_r + 16'h0001;
          end
        end
        default: begin
          smp_r <= CMAC_SMP_IDLE;
        end
      endcase
    end
  end

  // input mux: conversion channel while acquiring, parking channel between
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mux_sel <= 4'hF;
    end else begin
      o_mux_sel <= i_acq_active ? i_conv_chan : cmac_top_chan(chsel_r);  // [RL1]
    end
  end

  // stage one: factory corrections on every channel
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_valid_r <= 1'b0;
      s1_chan_r  <= 5'h00;
      s1_data_r  <= 16'h0000;
    end else begin
      s1_valid_r <= i_raw_valid;
      s1_chan_r  <= i_raw_chan;
      s1_data_r  <= cmac_corr(i_raw_data, $signed(i_fact_gain), $signed(i_fact_offs));
    end
  end

  // stage two: user corrections on top of the factory-corrected value
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_corr_valid <= 1'b0;
      o_corr_chan  <= 5'h00;
      o_corr_data  <= 16'h0000;
    end else begin
      o_corr_valid <= s1_valid_r;  // [RL5]
      o_corr_chan  <= s1_chan_r;
      if (s1_chan_r[`CMAC_AUX_CH_BIT]) begin
        o_corr_data <= cmac_corr(s1_data_r, 16'sh0000,
                                 16'($signed(aux_offs_r[s1_chan_r[2:0]][9:0])));  // [RL4] [RL10] [RL6]
      end else begin
        o_corr_data <= cmac_corr(s1_data_r, 16'($signed(cgain_r)),
                                 16'($signed(coffs_r)));  // [RL4] [RL8] [RL9] [RL6]
      end
    end
  end

  // register read decode
  always_comb begin
    rdata_nxt = 16'h0000;
    if (i_addr >= `CMAC_OFS_AUX0 && i_addr <= `CMAC_OFS_AUX7) begin
      rdata_nxt = aux_offs_r[3'(i_addr - `CMAC_OFS_AUX0)];
    end else begin
      case (i_addr)
        `CMAC_OFS_CHSEL:  rdata_nxt = chsel_r;
        `CMAC_OFS_CGAIN:  rdata_nxt = {8'h00, cgain_r};
        `CMAC_OFS_COFFS:  rdata_nxt = {8'h00, coffs_r};
        `CMAC_OFS_KEY1:   rdata_nxt = key1_r;
        `CMAC_OFS_KEY2:   rdata_nxt = key2_r;
        `CMAC_OFS_ADDR:   rdata_nxt = {11'h000, addr_r};
        `CMAC_OFS_DEVCFG: rdata_nxt = {15'h0000, addr_sel_r};
        `CMAC_OFS_BALCFG: rdata_nxt = {15'h0000, bal_stop_r};
        `CMAC_OFS_BALEN:  rdata_nxt = bal_en_r;
        `CMAC_OFS_PARK:   rdata_nxt = {14'h0000, park_act_r, park_req_r};
        `CMAC_OFS_STATUS: rdata_nxt = {13'h0000, blocked, ~o_hs_tx_en,
                                       adr_r == CMAC_ADR_AUTO};
        default:          rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rdata_nxt : 16'h0000;
    end
  end

endmodule
`default_nettype wire

// ---- cmac_params.svh ----
/*
  Constants of the cell monitor address and calibration block: register
  offsets, field positions, reset values, key values and timing counts.
  Assumes a 100 MHz clock and a register port with 8-bit address, 16-bit data.
*/
// Contract
// (RL1) between acquisitions mux parks on highest enabled cell channel
// (RL2) park bit set delays each cell sampling request by 100 us
// (RL3) park bit change takes effect after next front-end sample completes
// (RL4) user gain/offset apply to all cell channels, never to auxiliary channels
// (RL5) user corrections follow factory offset and gain corrections
// (RL6) corrections are signed two's complement; zero leaves result unchanged
// (RL7) cell gain correction is 8-bit signed, about +-9.7 mV full scale
// (RL8) gain correction scales with input level, half at half scale
// (RL9) one 8-bit signed cell offset correction added to all cell channels
// (RL10) eight 10-bit signed aux offsets in 16-bit registers, no aux gain
// (RL11) host keeps low 8 bits of gain value, saturating to signed limits
// (RL12) host reduces aux offsets to 10 signed bits, saturating
// (RL13) save to nonvolatile memory needs both unlock keys then save bit
// (RL14) reset reloads stored address; select bit 0 uses gpio address instead
// (RL15) select bit 0: address from five gpio pins at reset or auto bit
// (RL16) auto addressing entered only with select 1 and auto bit written 1
// (RL17) auto mode stops high-side transmit one frame, allows address writes
// (RL18) after that frame address writes blocked, high-side transmit restored
// (RL19) outside auto mode address field writes are ignored
// (RL20) host broadcasts auto bit then consecutive addresses
// (RL21) host reads back every address after auto addressing
// (RL22) fault during balancing with stop bit blocks writes about 2 us
// (RL23) host verifies writes near balancing faults and repeats them
`ifndef CMAC_PARAMS_SVH
`define CMAC_PARAMS_SVH

`define CMAC_CLK_MHZ          100
`define CMAC_PARK_DELAY_US    100
`define CMAC_PARK_DELAY_CYC   (`CMAC_PARK_DELAY_US * `CMAC_CLK_MHZ)
`define CMAC_BLOCK_US         2
`define CMAC_BLOCK_CYC        (`CMAC_BLOCK_US * `CMAC_CLK_MHZ)

`define CMAC_OFS_CHSEL        8'h00
`define CMAC_OFS_CGAIN        8'h01
`define CMAC_OFS_COFFS        8'h02
`define CMAC_OFS_AUX0         8'h03
`define CMAC_OFS_AUX7         8'h0A
`define CMAC_OFS_DEVCTL       8'h0B
`define CMAC_OFS_KEY1         8'h0C
`define CMAC_OFS_KEY2         8'h0D
`define CMAC_OFS_ADDR         8'h0E
`define CMAC_OFS_DEVCFG       8'h0F
`define CMAC_OFS_BALCFG       8'h10
`define CMAC_OFS_BALEN        8'h11
`define CMAC_OFS_PARK         8'h12
`define CMAC_OFS_STATUS       8'h13

`define CMAC_CTL_AUTO_BIT     0
`define CMAC_CTL_SAVE_BIT     1
`define CMAC_CFG_SEL_BIT      0
`define CMAC_BAL_STOP_BIT     0
`define CMAC_PARK_BIT         0
`define CMAC_PARK_ACT_BIT     1

`define CMAC_CHSEL_RST        16'hFFFF
// key values arbitrary
`define CMAC_KEY1_VAL         16'hA5C3
`define CMAC_KEY2_VAL         16'h3C5A
`define CMAC_AUX_CH_BIT       4

`endif

// ---- cmac_pkg.sv ----
/*
  Types of the cell monitor address and calibration block.
  Assumes the constants header is included by the design file.
*/
package cmac_pkg;
  typedef enum logic [1:0] {
    CMAC_SMP_IDLE = 2'b01,
    CMAC_SMP_WAIT = 2'b10
  } cmac_smp_t;

  typedef enum logic [1:0] {
    CMAC_ADR_NORM = 2'b01,
    CMAC_ADR_AUTO = 2'b10
  } cmac_adr_t;
endpackage

// ---- cmac_top_props.sv ----
/*
  Checker of cmac_top port relations: mux follow, correction latency,
  auto-address transmitter window, write-block length, save pulse.
  Assumes one clock domain with asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmac_params.svh"
module cmac_top_props #(
  parameter int unsigned P_PARK_DELAY_CYC = 20
) (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_acq_active,
  input wire logic [3:0]  i_conv_chan,
  input wire logic [3:0]  o_mux_sel,
  input wire logic        i_raw_valid,
  input wire logic [4:0]  i_raw_chan,
  input wire logic        o_corr_valid,
  input wire logic [4:0]  o_corr_chan,
  input wire logic        i_frame_done,
  input wire logic        o_hs_tx_en,
  input wire logic        i_fault,
  input wire logic        o_wr_blocked,
  input wire logic        o_nvm_save
);
  logic       auto_wr;
  logic       save_wr;
  logic [8:0] blk_cnt_r;
  assign auto_wr = i_wr && i_addr == `CMAC_OFS_DEVCTL && i_wdata[`CMAC_CTL_AUTO_BIT];
  assign save_wr = i_wr && i_addr == `CMAC_OFS_DEVCTL && i_wdata[`CMAC_CTL_SAVE_BIT];
  // blocked cycles since the last fault
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) blk_cnt_r <= 9'h000;
    else if (i_fault) blk_cnt_r <= 9'h000;
    else if (o_wr_blocked) blk_cnt_r <= blk_cnt_r + 9'h001;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_mux_follow_acq: assert property (
    $past(i_acq_active) |-> o_mux_sel == $past(i_conv_chan)) else $error("mux off channel");
  a_corr_two_cyc: assert property (
    i_raw_valid |-> ##2 o_corr_valid) else $error("result late");
  a_corr_cause: assert property (
    o_corr_valid |-> $past(i_raw_valid, 2)) else $error("result without sample");
  a_corr_chan_kept: assert property (
    i_raw_valid |-> ##2 (o_corr_chan == $past(i_raw_chan, 2))) else $error("channel lost");
  a_tx_off_cause: assert property (
    $fell(o_hs_tx_en) |-> $past(auto_wr) || $past(auto_wr, 2)) else $error("tx off uncaused");
  a_tx_back_frame: assert property (
    (!o_hs_tx_en && i_frame_done) |-> ##[1:2] o_hs_tx_en) else $error("tx not restored");
  a_block_cause: assert property (
    $rose(o_wr_blocked) |-> $past(i_fault)) else $error("block without fault");
  a_block_length: assert property (
    $fell(o_wr_blocked) |-> blk_cnt_r == 9'h0C8) else $error("block window length");
  a_save_cause: assert property (
    o_nvm_save |-> $past(save_wr) ##1 !o_nvm_save) else $error("bad save pulse");
  c_block: cover property ($rose(o_wr_blocked));
  c_auto: cover property ($fell(o_hs_tx_en));
  c_save: cover property (o_nvm_save);
  c_corr: cover property (o_corr_valid);
endmodule
bind cmac_top cmac_top_props #(.P_PARK_DELAY_CYC(P_PARK_DELAY_CYC)) u_props (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_acq_active(i_acq_active), .i_conv_chan(i_conv_chan), .o_mux_sel(o_mux_sel),
  .i_raw_valid(i_raw_valid), .i_raw_chan(i_raw_chan), .o_corr_valid(o_corr_valid),
  .o_corr_chan(o_corr_chan), .i_frame_done(i_frame_done), .o_hs_tx_en(o_hs_tx_en),
  .i_fault(i_fault), .o_wr_blocked(o_wr_blocked), .o_nvm_save(o_nvm_save));
`default_nettype wire

// ---- cmac_host.sv ----
/*
  Host model: one-cycle register strobes, saturation of computed
  corrections and the keyed save sequence.
  Assumes the bench clock and a slave that never stalls.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmac_params.svh"
module cmac_host (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  output var  logic [7:0]  o_addr,
  output var  logic [15:0] o_wdata,
  output var  logic        o_wr,
  output var  logic        o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
  function automatic logic [15:0] sat8(input int v);
    return (v > 127) ? 16'h007F : (v < -128) ? 16'h0080 : 16'(v) & 16'h00FF;
  endfunction
  function automatic logic [15:0] sat10(input int v);
    return (v > 511) ? 16'h01FF : (v < -512) ? 16'hFE00 : 16'(v);
  endfunction
  task automatic save(input logic [15:0] k1, input logic [15:0] k2);
    wr(`CMAC_OFS_KEY1, k1);
    wr(`CMAC_OFS_KEY2, k2);
    wr(`CMAC_OFS_DEVCTL, 16'h0002);
  endtask
endmodule
`default_nettype wire

// ---- cmac_top_bench.sv ----
/*
  Self-checking bench of cmac_top with the host model on the register port.
  Assumes 100 MHz clock and a shortened park delay parameter.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmac_params.svh"
module cmac_top_bench
  import cmac_pkg::*;
;
  localparam int unsigned P = 20;
  logic        i_clk, i_nrst, i_wr, i_rd, i_nvm_addr_sel, i_frame_done, i_acq_active;
  logic        i_sample_req, i_sample_done, i_raw_valid, i_fault;
  logic        o_nvm_save, o_hs_tx_en, o_sample_go, o_corr_valid, o_wr_blocked;
  logic [7:0]  i_addr;
  logic [15:0] i_wdata, o_rdata, i_raw_data, i_fact_gain, i_fact_offs, o_corr_data, d, g, o, a;
  logic [4:0]  i_gpio_addr, i_nvm_addr, o_address_field, i_raw_chan, o_corr_chan;
  logic [3:0]  i_conv_chan, o_mux_sel;
  int          bad_count, check_count, n, fo, gi, fg, y;
  cmac_top #(.P_PARK_DELAY_CYC(P)) DUT (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_gpio_addr(i_gpio_addr), .i_nvm_addr(i_nvm_addr),
    .i_nvm_addr_sel(i_nvm_addr_sel), .o_address_field(o_address_field), .o_nvm_save(o_nvm_save),
    .i_frame_done(i_frame_done), .o_hs_tx_en(o_hs_tx_en), .i_acq_active(i_acq_active),
    .i_conv_chan(i_conv_chan), .o_mux_sel(o_mux_sel), .i_sample_req(i_sample_req),
    .i_sample_done(i_sample_done), .o_sample_go(o_sample_go), .i_raw_valid(i_raw_valid),
    .i_raw_chan(i_raw_chan), .i_raw_data(i_raw_data), .i_fact_gain(i_fact_gain),
    .i_fact_offs(i_fact_offs), .o_corr_valid(o_corr_valid), .o_corr_chan(o_corr_chan),
    .o_corr_data(o_corr_data), .i_fault(i_fault), .o_wr_blocked(o_wr_blocked));
  cmac_host u_host (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [3:0] top_chan(input logic [15:0] v);
    for (int b = 15; b > 0; b--) if (v[b]) return 4'(b);
    return v[0] ? 4'h0 : 4'hF;
  endfunction
  task automatic conv(input logic [4:0] ch, input int exp);
    @(posedge i_clk);
    i_raw_valid <= 1'b1;
    i_raw_chan <= ch;
    i_raw_data <= 16'(32768 - fo);
    @(posedge i_clk);
    i_raw_valid <= 1'b0;
    @(posedge i_clk);
    #1;
    chk(16'(o_corr_valid), 16'h0001);
    chk(16'(o_corr_chan), 16'(ch));
    chk(o_corr_data, 16'(exp));
  endtask
  task automatic go_lat;
    @(posedge i_clk) i_sample_req <= 1'b1;
    @(posedge i_clk) i_sample_req <= 1'b0;
    for (n = 0; n < P + 4; n++) begin
      #1;
      if (o_sample_go === 1'b1) break;
      @(posedge i_clk);
    end
    if (n >= P + 4) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  initial begin
    {i_nrst, i_nvm_addr_sel, i_frame_done, i_acq_active, i_sample_req} = 5'h00;
    {i_sample_done, i_raw_valid, i_fault, i_conv_chan, i_raw_chan} = 12'h000;
    {i_raw_data, i_fact_gain, i_fact_offs} = 48'h0;
    i_gpio_addr = 5'h13;
    i_nvm_addr = 5'h06;
    bad_count = 0;
    check_count = 0;
    void'($urandom(69977));
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chk(16'(o_address_field), 16'h0013);
    chk(16'(o_mux_sel), 16'h000F);
    u_host.rd(8'h3F, d);
    chk(d, 16'h0000);
    u_host.wr(`CMAC_OFS_ADDR, 16'h0007);
    u_host.rd(`CMAC_OFS_ADDR, d);
    chk(d, 16'h0013);
    @(posedge i_clk) i_gpio_addr <= 5'h0A;
    u_host.wr(`CMAC_OFS_DEVCTL, 16'h0001);
    repeat (2) @(posedge i_clk);
    #1;
    chk(16'(o_address_field), 16'h000A);
    chk(16'(o_hs_tx_en), 16'h0001);
    @(posedge i_clk) i_nvm_addr_sel <= 1'b1;
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk) i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chk(16'(o_address_field), 16'h0006);
    u_host.wr(`CMAC_OFS_DEVCTL, 16'h0001);
    @(posedge i_clk);
    #1;
    chk(16'(o_hs_tx_en), 16'h0000);
    u_host.wr(`CMAC_OFS_ADDR, 16'h0009);
    @(posedge i_clk) i_frame_done <= 1'b1;
    @(posedge i_clk) i_frame_done <= 1'b0;
    @(posedge i_clk);
    #1;
    chk(16'(o_hs_tx_en), 16'h0001);
    u_host.wr(`CMAC_OFS_ADDR, 16'h001F);
    u_host.rd(`CMAC_OFS_ADDR, d);
    chk(d, 16'h0009);
    for (int i = 0; i < 6; i++) begin
      d = 16'($urandom) >> (i * 3);
      u_host.wr(`CMAC_OFS_CHSEL, d);
      @(posedge i_clk);
      #1;
      chk(16'(o_mux_sel), 16'(top_chan(d)));
      @(posedge i_clk) i_acq_active <= 1'b1;
      i_conv_chan <= 4'($urandom);
      @(posedge i_clk) i_acq_active <= 1'b0;
    end
    for (int i = 0; i < 8; i++) begin
      gi = (i == 1) ? -200 : (i == 2) ? 200 : $urandom_range(320) - 160;
      g = (i == 0) ? 16'h0000 : u_host.sat8(gi) & 16'hFFFE;
      o = (i == 0) ? 16'h0000 : u_host.sat8($urandom_range(400) - 200);
      a = (i == 0) ? 16'h0000 : u_host.sat10($urandom_range(1400) - 700);
      fo = $urandom_range(1023);
      fg = $urandom_range(2000) - 1000;
      y = 32768 - fo;
      y = y + ((y * fg) >>> 16) + fo;
      @(posedge i_clk) i_fact_offs <= 16'(fo);
      i_fact_gain <= 16'(fg);
      u_host.wr(`CMAC_OFS_CGAIN, g);
      u_host.wr(`CMAC_OFS_COFFS, o);
      u_host.wr(8'(`CMAC_OFS_AUX0 + i), a);
      gi = y + (($signed(g[7:0]) * y) >>> 16) + $signed(o[7:0]);
      conv(5'($urandom_range(15)), gi);
      conv(5'(16 + i), y + $signed(a[9:0]));
    end
    go_lat();
    chk(16'(n), 16'h0000);
    u_host.wr(`CMAC_OFS_PARK, 16'h0001);
    go_lat();
    chk(16'(n), 16'h0000);
    @(posedge i_clk) i_sample_done <= 1'b1;
    @(posedge i_clk) i_sample_done <= 1'b0;
    u_host.rd(`CMAC_OFS_PARK, d);
    chk(d, 16'h0003);
    go_lat();
    chk(16'(n), 16'(P));
    u_host.wr(`CMAC_OFS_BALCFG, 16'h0001);
    u_host.wr(`CMAC_OFS_BALEN, 16'h0000);
    @(posedge i_clk) i_fault <= 1'b1;
    @(posedge i_clk) i_fault <= 1'b0;
    #1;
    chk(16'(o_wr_blocked), 16'h0000);
    u_host.wr(`CMAC_OFS_BALEN, 16'h0004);
    @(posedge i_clk) i_fault <= 1'b1;
    @(posedge i_clk) i_fault <= 1'b0;
    u_host.wr(`CMAC_OFS_CGAIN, 16'h0055);
    #1;
    chk(16'(o_wr_blocked), 16'h0001);
    u_host.rd(`CMAC_OFS_CGAIN, d);
    chk(d, g);
    for (n = 0; n < 300 && o_wr_blocked !== 1'b0; n++) begin
      @(posedge i_clk);
      #1;
    end
    if (n >= 300) begin
      bad_count++;
      tally_and_finish();
    end
    u_host.wr(`CMAC_OFS_CGAIN, 16'h0055);
    u_host.rd(`CMAC_OFS_CGAIN, d);
    chk(d, 16'h0055);
    u_host.save(`CMAC_KEY1_VAL, `CMAC_KEY2_VAL);
    #1;
    chk(16'(o_nvm_save), 16'h0001);
    u_host.save(`CMAC_KEY1_VAL, 16'h0000);
    #1;
    chk(16'(o_nvm_save), 16'h0000);
    u_host.rd(`CMAC_OFS_DEVCTL, d);
    chk(d, 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
